// ---- rtl/pin_pkg.sv ----
// Purpose: Shared constants for the port pin multiplex block
// Assumes: Single 50 MHz clock
// Notes:   Pin functions and reset stretch timing
package pin_pkg;
	localparam int          CLK_MHZ        = 50;
	localparam int          PLL_OFF_CYCLES = 512;
	localparam int          PLL_LOCK_US    = 100;
	localparam int          PLL_LOCK_CYCLES_BASE = PLL_LOCK_US * CLK_MHZ;
	localparam int          PORT_W         = 8;
	localparam int          IRQ_W          = 4;
	localparam int          RST_PIN        = 4;
	localparam logic [7:0]  DIR_RESET      = 8'h10;
	localparam logic [7:0]  OUT_RESET      = 8'h00;
	typedef enum logic [1:0] {
		FN_GPIO   = 2'h0,
		FN_SERIAL = 2'h1,
		FN_ALT    = 2'h3
	} pin_fn_t;
	typedef enum logic [1:0] {
		ST_HOLD    = 2'h0,
		ST_STRETCH = 2'h1,
		ST_RUN     = 2'h3
	} rst_state_t;
endpackage : pin_pkg

// ---- rtl/irq_if.sv ----
// Purpose: Carries synchronised level interrupts to the main module
// Assumes: Same clock on both ends
// Notes:   Levels only, no pulses
`timescale 1ns/1ns
`default_nettype none
interface irq_if;
	logic [3:0] level;
	modport src (output level);
	modport dst (input level);
endinterface : irq_if
`default_nettype wire

// ---- rtl/level_irq_sync.sv ----
// Purpose: Three-stage synchroniser for asynchronous interrupt levels
// Assumes: Inputs are asynchronous pins
// Notes:   A change counts once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module level_irq_sync (
	// Clock and reset
	input  wire logic CLK,
	input  wire logic RST_B,
	// Pins
	input  wire logic [3:0] pin_in,
	// Synchronised levels
	irq_if.src        irq
);
	import pin_pkg::*;
	logic [3:0] s1;
	logic [3:0] s2;
	logic [3:0] s3;
	logic [3:0] level_q;
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			s1 <= 4'h0;
			s2 <= 4'h0;
			s3 <= 4'h0;
		end else begin
			s1 <= pin_in;   // [RULE_06]
			s2 <= s1;
			s3 <= s2;
		end
	end
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_lvl
			// Level follows pin only, no software clear
			always_ff @(posedge CLK) begin
				if (!RST_B)
					level_q[i] <= 1'b0;
				else if (s2[i] == s3[i])
					level_q[i] <= s3[i];   // [RULE_07]
			end
		end
	endgenerate
	assign irq.level = level_q;
	a_level_follow: assert property (@(posedge CLK) disable iff (!RST_B)
		(s2 == s3) |=> (level_q == $past(s3)))
		else $error("irq level not tracking pin"); // [RULE_07]
endmodule : level_irq_sync
`default_nettype wire

// ---- rtl/gpio_reset_irq_pins.sv ----
// Purpose: Port A and C pin multiplex with reset indicator and level irqs
// Assumes: All registers on CLK; other domains enter as sampled levels, except CRYSTAL_OUT, which inverts CRYSTAL_IN directly
// Notes:   Serial, DMA and encoding logic sit outside this block
// Summary of operation
// RULE_01: A port C pin shows whether the chip is held in reset.
// RULE_02: PLL off: indicator stays active 512 cycles after reset release.
// RULE_03: PLL on: indicator held 100 us times VCO to crystal ratio.
// RULE_04: After reset the indicator pin is an output, active.
// RULE_05: Four low port C pins serve as level interrupt inputs.
// RULE_06: Interrupt pins are asynchronous and are synchronised first.
// RULE_07: Interrupt stays active until the pin level changes.
// RULE_08: System, crystal reference and bus clock domains are accepted.
// RULE_09: Active low chip reset clears all logic. The PLL strap stages pll_s1 to pll_s3 have no reset here.
// RULE_10: Each pin selects GPIO, serial signal or alternate function.
`timescale 1ns/1ns
`default_nettype none
module gpio_reset_irq_pins #(
	parameter int PLL_RATIO = 4,
	parameter int LOCK_CYCLES = pin_pkg::PLL_LOCK_CYCLES_BASE * PLL_RATIO
) (
	// Clock and reset
	input  wire logic                    CLK,
	input  wire logic                    RST_B,
	input  wire logic                    PLL_ENABLE,
	// Other clock domains as sampled levels; CRYSTAL_OUT inverts CRYSTAL_IN directly
	input  wire logic                    CRYSTAL_IN,
	input  wire logic                    BUS_CLK_IN,
	output logic                         CRYSTAL_OUT,
	output logic                         REF_TICK,
	output logic                         BUS_TICK,
	// Pin configuration
	input  wire logic [15:0]             FN_SEL_A,
	input  wire logic [15:0]             FN_SEL_C,
	input  wire logic [7:0]              GPIO_DIR_A,
	input  wire logic [7:0]              GPIO_DIR_C,
	input  wire logic [7:0]              GPIO_OUT_A,
	input  wire logic [7:0]              GPIO_OUT_C,
	// Serial and alternate sources
	input  wire logic [7:0]              SER_OUT_A,
	input  wire logic [7:0]              SER_OE_A,
	input  wire logic [7:0]              SER_OUT_C,
	input  wire logic [7:0]              SER_OE_C,
	input  wire logic [7:0]              ALT_OUT_A,
	input  wire logic [7:0]              ALT_OE_A,
	input  wire logic [7:0]              ALT_OUT_C,
	input  wire logic [7:0]              ALT_OE_C,
	// Pins, enable low drives
	input  wire logic [7:0]              PORT_A_IN,
	output logic [7:0]                   PORT_A_OUT,
	output logic [7:0]                   PORT_A_OE_B,
	input  wire logic [7:0]              PORT_C_IN,
	output logic [7:0]                   PORT_C_OUT,
	output logic [7:0]                   PORT_C_OE_B,
	// Status
	output logic [7:0]                   PIN_IN_A,
	output logic [7:0]                   PIN_IN_C,
	output logic [3:0]                   LEVEL_IRQ,
	output logic                         CHIP_IN_RESET
);
	import pin_pkg::*;
	localparam int CW = 24;
	localparam logic [CW-1:0] OFF_LAST  = CW'(PLL_OFF_CYCLES - 1);
	localparam logic [CW-1:0] LOCK_LAST = CW'(LOCK_CYCLES - 1);

	irq_if irq ();
	rst_state_t  state;
	logic [CW-1:0] cnt;
	logic        pll_s1, pll_s2, pll_s3, pll_en;
	logic [2:0]  xs, bs;
	logic [7:0]  a_s1, a_s2, c_s1, c_s2;

	function automatic pin_fn_t fn_of(input logic [15:0] sel,
		input int i);
		logic [1:0] v;
		v = sel[2*i +: 2];
		if (v == 2'h1)
			return FN_SERIAL;
		else if (v[1])
			return FN_ALT;
		else
			return FN_GPIO;
	endfunction : fn_of

	level_irq_sync u_sync (
		.CLK    (CLK),
		.RST_B  (RST_B),
		.pin_in (PORT_C_IN[3:0]),   // [RULE_05]
		.irq    (irq.src)
	);
	assign LEVEL_IRQ = irq.level;   // [RULE_05]

	// PLL enable strap, three stages, kept running in reset
	// So the strap is settled when the hold cycle takes it
	always_ff @(posedge CLK) begin
		pll_s1 <= PLL_ENABLE;
		pll_s2 <= pll_s1;
		pll_s3 <= pll_s2;
	end

	// Reset stretch sequencer
	always_ff @(posedge CLK) begin
		if (!RST_B) begin   // [RULE_09]
			state  <= ST_HOLD;
			cnt    <= '0;
			pll_en <= 1'b0;
		end else begin
			case (state)
				ST_HOLD: begin
					if (pll_s2 == pll_s3)
						pll_en <= pll_s3;   // [RULE_03]
					cnt    <= '0;
					state  <= ST_STRETCH;
				end
				ST_STRETCH: begin
					if ((!pll_en && cnt == OFF_LAST) ||   // [RULE_02]
					    (pll_en && cnt == LOCK_LAST))      // [RULE_03]
						state <= ST_RUN;
					else
						cnt <= cnt + 1'b1;
				end
				default: state <= ST_RUN;
			endcase
		end
	end
	assign CHIP_IN_RESET = (state != ST_RUN);   // [RULE_01]

	// Other domains sampled, one-cycle tick on rising edge
	always_ff @(posedge CLK) begin
		if (!RST_B) begin   // [RULE_08]
			xs       <= 3'h0;
			bs       <= 3'h0;
			REF_TICK <= 1'b0;
			BUS_TICK <= 1'b0;
		end else begin
			xs       <= {xs[1:0], CRYSTAL_IN};
			bs       <= {bs[1:0], BUS_CLK_IN};
			REF_TICK <= xs[1] & ~xs[2];
			BUS_TICK <= bs[1] & ~bs[2];
		end
	end
	assign CRYSTAL_OUT = ~CRYSTAL_IN;

	// Input sampling of port pins
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			a_s1 <= 8'h00;
			a_s2 <= 8'h00;
			c_s1 <= 8'h00;
			c_s2 <= 8'h00;
			PIN_IN_A <= 8'h00;
			PIN_IN_C <= 8'h00;
		end else begin
			a_s1 <= PORT_A_IN;
			a_s2 <= a_s1;
			c_s1 <= PORT_C_IN;
			c_s2 <= c_s1;
			PIN_IN_A <= a_s2;
			PIN_IN_C <= c_s2;
		end
	end

	// Output multiplex per pin
	always_ff @(posedge CLK) begin
		if (!RST_B) begin   // [RULE_04]
			PORT_A_OUT  <= 8'h00;
			PORT_A_OE_B <= 8'hff;
			PORT_C_OUT  <= OUT_RESET;
			PORT_C_OE_B <= ~DIR_RESET;
		end else begin
			for (int i = 0; i < PORT_W; i++) begin
				case (fn_of(FN_SEL_A, i))   // [RULE_10]
					FN_SERIAL: begin
						PORT_A_OUT[i]  <= SER_OUT_A[i];
						PORT_A_OE_B[i] <= ~SER_OE_A[i];
					end
					FN_ALT: begin
						PORT_A_OUT[i]  <= ALT_OUT_A[i];
						PORT_A_OE_B[i] <= ~ALT_OE_A[i];
					end
					default: begin
						PORT_A_OUT[i]  <= GPIO_OUT_A[i];
						PORT_A_OE_B[i] <= ~GPIO_DIR_A[i];
					end
				endcase
				case (fn_of(FN_SEL_C, i))   // [RULE_10]
					FN_SERIAL: begin
						PORT_C_OUT[i]  <= SER_OUT_C[i];
						PORT_C_OE_B[i] <= ~SER_OE_C[i];
					end
					FN_ALT: begin
						PORT_C_OUT[i]  <= ALT_OUT_C[i];
						PORT_C_OE_B[i] <= ~ALT_OE_C[i];
					end
					default: begin
						PORT_C_OUT[i]  <= GPIO_OUT_C[i];
						PORT_C_OE_B[i] <= ~GPIO_DIR_C[i];
					end
				endcase
			end
			// Reset indicator overrides, active low
			if (CHIP_IN_RESET) begin
				PORT_C_OUT[RST_PIN]  <= 1'b0;   // [RULE_01]
				PORT_C_OE_B[RST_PIN] <= 1'b0;   // [RULE_04]
			end
		end
	end

	// Stretch length counter for checks
	logic [CW-1:0] run_len;
	always_ff @(posedge CLK) begin
		if (!RST_B)
			run_len <= '0;
		else if (CHIP_IN_RESET)
			run_len <= run_len + 1'b1;
	end

	a_stretch_off: assert property (@(posedge CLK) disable iff (!RST_B)
		($rose(state == ST_RUN) && !pll_en) |-> run_len == CW'(PLL_OFF_CYCLES + 1))
		else $error("stretch length wrong without pll"); // [RULE_02]
	a_stretch_lock: assert property (@(posedge CLK) disable iff (!RST_B)
		($rose(state == ST_RUN) && pll_en) |-> run_len == CW'(LOCK_CYCLES + 1))
		else $error("stretch length wrong with pll"); // [RULE_03]
	a_indicator_pin: assert property (@(posedge CLK) disable iff (!RST_B)
		$past(CHIP_IN_RESET) |-> (!PORT_C_OUT[RST_PIN] && !PORT_C_OE_B[RST_PIN]))
		else $error("reset indicator not driven"); // [RULE_01]
	a_reset_drive: assert property (@(posedge CLK)
		!RST_B |=> (!PORT_C_OE_B[RST_PIN] && CHIP_IN_RESET))
		else $error("indicator not output after reset"); // [RULE_04]
	a_run_stays: assert property (@(posedge CLK) disable iff (!RST_B)
		(state == ST_RUN) |=> (state == ST_RUN))
		else $error("left run state without reset"); // [RULE_09]
	a_gpio_mux: assert property (@(posedge CLK) disable iff (!RST_B)
		(FN_SEL_A[1:0] == 2'h0) |=> PORT_A_OUT[0] == $past(GPIO_OUT_A[0]))
		else $error("gpio mux wrong"); // [RULE_10]
	a_ser_mux: assert property (@(posedge CLK) disable iff (!RST_B)
		(FN_SEL_A[1:0] == 2'h1) |=> PORT_A_OE_B[0] == !$past(SER_OE_A[0]))
		else $error("serial mux wrong"); // [RULE_10]
	a_irq_path: assert property (@(posedge CLK) disable iff (!RST_B)
		(PORT_C_IN[0] [*6]) |-> LEVEL_IRQ[0])
		else $error("irq pin not reaching output"); // [RULE_05]
	c_stretch_done: cover property (@(posedge CLK) disable iff (!RST_B)
		$fell(CHIP_IN_RESET));
	c_irq_rise: cover property (@(posedge CLK) disable iff (!RST_B)
		$rose(LEVEL_IRQ[3]));
	c_alt_pin: cover property (@(posedge CLK) disable iff (!RST_B)
		FN_SEL_C[13:12] == 2'h3 && !CHIP_IN_RESET);
endmodule : gpio_reset_irq_pins
`default_nettype wire

// ---- test/port_board.sv ----
// Purpose: Board side of the port pins, pulled up when idle
// Assumes: External drivers enabled per bit
// Notes:   Device drive wins over a board driver
`timescale 1ns/1ns
`default_nettype none
module port_board (
	// Device side
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe_b,
	// Board drivers
	input  wire logic [7:0] ext_val,
	input  wire logic [7:0] ext_en,
	// Resolved pin level
	output logic      [7:0] level
);
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!pin_oe_b[i])
				level[i] = pin_out[i];
			else if (ext_en[i])
				level[i] = ext_val[i];
			else
				level[i] = 1'b1;
		end
	end
endmodule : port_board
`default_nettype wire

// ---- test/tb_gpio_reset_irq_pins.sv ----
// Purpose: Self-checking bench for the port pin block
// Assumes: Short lock count, board model with pull-ups
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/1ns
`default_nettype none
module tb_gpio_reset_irq_pins;
	import pin_pkg::*;
	localparam int LOCK = 20;
	logic clk = 0, rst_b = 0, pll = 0, xtal = 0, bclk = 0;
	logic [15:0] fa = 16'h0000, fc = 16'h0000;
	logic [7:0] da = 8'hf0, dc = 8'hf0, oa = 8'h5a, oc = 8'h5a;
	logic [7:0] sa = 8'h33, sc = 8'h33, sea = 8'h0f, sec = 8'h0f;
	logic [7:0] aa = 8'hc3, ac = 8'hc3, aea = 8'h3c, aec = 8'h3c;
	logic [7:0] exv = 8'h00, exe = 8'h00;
	logic [7:0] pa_in, pa_out, pa_oeb, pc_in, pc_out, pc_oeb, pin_a, pin_c;
	logic [3:0] irq;
	logic       xout, rtick, btick, in_rst;
	int         error_cnt = 0, num_checks = 0, rcnt = 0, bcnt = 0;
	always #10 clk = ~clk;
	gpio_reset_irq_pins #(.LOCK_CYCLES(LOCK)) dut (
		.CLK(clk), .RST_B(rst_b), .PLL_ENABLE(pll), .CRYSTAL_IN(xtal),
		.BUS_CLK_IN(bclk), .CRYSTAL_OUT(xout), .REF_TICK(rtick),
		.BUS_TICK(btick), .FN_SEL_A(fa), .FN_SEL_C(fc), .GPIO_DIR_A(da),
		.GPIO_DIR_C(dc), .GPIO_OUT_A(oa), .GPIO_OUT_C(oc), .SER_OUT_A(sa),
		.SER_OE_A(sea), .SER_OUT_C(sc), .SER_OE_C(sec), .ALT_OUT_A(aa),
		.ALT_OE_A(aea), .ALT_OUT_C(ac), .ALT_OE_C(aec), .PORT_A_IN(pa_in),
		.PORT_A_OUT(pa_out), .PORT_A_OE_B(pa_oeb), .PORT_C_IN(pc_in),
		.PORT_C_OUT(pc_out), .PORT_C_OE_B(pc_oeb), .PIN_IN_A(pin_a),
		.PIN_IN_C(pin_c), .LEVEL_IRQ(irq), .CHIP_IN_RESET(in_rst));
	port_board board_a (.pin_out(pa_out), .pin_oe_b(pa_oeb),
		.ext_val(8'h00), .ext_en(8'h00), .level(pa_in));
	port_board board_c (.pin_out(pc_out), .pin_oe_b(pc_oeb),
		.ext_val(exv), .ext_en(exe), .level(pc_in));
	always @(posedge clk) begin
		if (rtick === 1'b1)
			rcnt <= rcnt + 1;
		if (btick === 1'b1)
			bcnt <= bcnt + 1;
	end
	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic reset_run(input logic pll_on, input int exp_n);
		int n;
		n = 0;
		pll = pll_on;
		rst_b = 0;
		step(6);
		chk("in_reset", 16'h1, 16'(in_rst));
		chk("c_oe_b", 16'h00ef, 16'(pc_oeb));
		chk("c_out4", 16'h0, 16'(pc_out[4]));
		chk("a_oe_b", 16'h00ff, 16'(pa_oeb));
		chk("irq_rst", 16'h0, 16'(irq));
		rst_b = 1;
		while (in_rst === 1'b1 && n < 30000) begin
			step(1);
			n++;
		end
		// Count includes the hold cycle after release
		chk("stretch", 16'(exp_n), 16'(n));
		step(2);
		chk("c4_free", 16'(!dc[4]), 16'(pc_oeb[4]));
		chk("c4_out", 16'(oc[4]), 16'(pc_out[4]));
	endtask : reset_run
	task automatic mux_run();
		logic [7:0] eo, eb;
		for (int k = 0; k < 4; k++) begin
			fa = {8{2'(k)}};
			fc = fa;
			step(5);
			eo = (k == 0) ? oa : (k == 1) ? sa : aa;
			eb = (k == 0) ? ~da : (k == 1) ? ~sea : ~aea;
			chk("a_oe_b", 16'(eb), 16'(pa_oeb));
			chk("a_out", 16'(eo & ~eb), 16'(pa_out & ~pa_oeb));
			chk("c_oe_b", 16'(eb), 16'(pc_oeb));
			chk("c_out", 16'(eo & ~eb), 16'(pc_out & ~pc_oeb));
			chk("pin_a", 16'((eo & ~eb) | eb), 16'(pin_a));
			chk("pin_c", 16'((eo & ~eb) | eb), 16'(pin_c));
		end
	endtask : mux_run
	task automatic clk_run();
		int r0, b0;
		r0 = rcnt;
		b0 = bcnt;
		for (int k = 0; k < 16; k++) begin
			xtal = ~xtal;
			if (k % 2 == 0)
				bclk = ~bclk;
			step(5);
			chk("xtal_out", 16'(!xtal), 16'(xout));
		end
		chk("ref_ticks", 16'h8, 16'(rcnt - r0));
		chk("bus_ticks", 16'h4, 16'(bcnt - b0));
	endtask : clk_run
	task automatic irq_run();
		int n;
		fc = 16'h0000;
		dc = 8'h00;
		exe = 8'h0f;
		exv = 8'h00;
		step(8);
		chk("irq_idle", 16'h0, 16'(irq));
		for (int i = 0; i < 4; i++) begin
			exv = 8'(1 << i);
			n = 0;
			while (irq !== exv[3:0] && n < 8) begin
				step(1);
				n++;
			end
			chk("irq_lat", 16'h4, 16'(n));
			step(20);
			chk("irq_hold", 16'(exv), 16'(irq));
		end
		exv = 8'h00;
		step(6);
		chk("irq_clear", 16'h0, 16'(irq));
		exe = 8'h00;
	endtask : irq_run
	task automatic results();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results
	initial begin
		reset_run(1'b0, PLL_OFF_CYCLES + 1);
		mux_run();
		clk_run();
		irq_run();
		reset_run(1'b1, LOCK + 1);
		results();
	end
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		results();
	end
endmodule : tb_gpio_reset_irq_pins
`default_nettype wire
